// *** rtl/serial_cfg_pkg.sv ***
// Package of register offsets, field positions, reset values and carriers for the serial config core
`default_nettype none
package serial_cfg_pkg;
  // ************************************************************
  // Register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [7:0] ADDR_BAUD_HIGH = 8'h00;
  localparam logic [7:0] ADDR_BAUD_LOW = 8'h04;
  localparam logic [7:0] ADDR_LINE_CTRL = 8'h08;
  localparam logic [7:0] ADDR_AUX_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_TX_DATA = 8'h14;
  localparam logic [7:0] ADDR_RX_DATA = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam int ADDR_W = 8;
  localparam int DIV_W = 13;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BH_BRK_IE = 7;
  localparam int BH_EDGE_IE = 6;
  localparam int BH_DIV_MSB = 4;
  localparam int LC_LOOP = 7;
  localparam int LC_FREEZE = 6;
  localparam int LC_RECEIVER_SOURCE = 5;
  localparam int LC_NINE = 4;
  localparam int LC_WAKE = 3;
  localparam int LC_ILT = 2;
  localparam int LC_PE = 1;
  localparam int LC_PT = 0;
  localparam int AX_TE = 3;
  localparam int AX_RE = 2;
  localparam int FL_BRK = 1;
  localparam int FL_EDGE = 0;
  // ************************************************************
  // Reset values and masks
  // ************************************************************
  localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
  localparam logic [7:0] RST_BAUD_LOW = 8'h04;
  localparam logic [7:0] RST_LINE_CTRL = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL = 8'h00;
  localparam logic [7:0] BAUD_HIGH_MASK = 8'hDF;
  localparam logic [12:0] DIV_ZERO = 13'h0000;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] IDLE_BITS_SHORT = 4'hA;
  localparam logic [3:0] IDLE_BITS_LONG = 4'hB;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [3:0] TICK_ZERO = 4'h0;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic loop_sel;
    logic freeze_in_wait;
    logic receiver_source;
    logic nine_bit;
    logic wake_addr_mark;
    logic idle_after_stop;
    logic parity_enable;
    logic parity_odd_select;
  } line_cfg_t;
  typedef struct packed {
    logic [8:0] data;
  } char_t;
endpackage
`default_nettype wire

// *** rtl/serial_cfg_core.sv ***
// Baud divisor, line control and minimal framing core for the serial port, AXI4-Lite slave
`default_nettype none
module serial_cfg_core
  import serial_cfg_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic cpu_wait_in,
  input wire logic rx_pin_in,
  input wire logic tx_pin_in,
  input wire logic break_event_in,
  output logic tx_pin_out,
  output logic tx_pin_oe_out,
  output logic rx_pin_serial_out,
  output logic bit_tick_out,
  output logic irq_out,
  output logic [8:0] rx_char_out,
  output logic rx_char_valid_out,
  output logic parity_error_out,
  output logic idle_line_out
);
  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0] baud_divisor_high;
  logic [4:0] div_high_buf;
  logic [DIV_W-1:0] baud_divisor;
  logic [7:0] baud_divisor_low;
  line_cfg_t line_control_one;
  logic tx_enable_bit, rx_enable_bit, gen_armed;
  logic break_detect_flag, rx_edge_flag;
  // Write channel holding
  logic aw_held, w_held, wr_fire;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] wbyte;
  // Two-entry transmit buffer
  char_t buf_mem [2];
  logic buf_wp, buf_rp;
  logic [1:0] buf_cnt;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  // Baud and shifters
  logic [DIV_W-1:0] div_cnt;
  logic [3:0] os_cnt;
  logic clk_run, os_tick, tx_busy;
  logic [10:0] tx_shift;
  logic [3:0] tx_left, tx_os;
  logic rx_line, rx_prev, rx_busy;
  logic [3:0] rx_os, rx_bits;
  logic [8:0] rx_shift;
  logic [3:0] idle_cnt;
  logic stop_ok;
  // Parity of a character of seven or eight data bits
  function automatic logic char_parity(input logic [8:0] d, input logic nine);
    char_parity = nine ? ^d[7:0] : ^d[6:0];
  endfunction
  // Decode of one byte-lane write to a slot
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction
  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
  assign wbyte = w_data[7:0];
  // Address and data accepted in either order, response after both
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (aw_addr[1:0] != 2'b00 || aw_addr > ADDR_STATUS) ? RESP_SLVERR
                                                                           : RESP_OKAY;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end
  // Ready is offered while the slot is empty
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held && !(s_axi_awvalid_in && s_axi_awready_out) && !wr_fire;
      s_axi_wready_out <= !w_held && !(s_axi_wvalid_in && s_axi_wready_out) && !wr_fire;
    end
  end
  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Divisor pair, interrupt enables, line control and enables
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      baud_divisor_high <= RST_BAUD_HIGH;
      div_high_buf <= RST_BAUD_HIGH[4:0];
      baud_divisor_low <= RST_BAUD_LOW;
      baud_divisor <= {RST_BAUD_HIGH[4:0], RST_BAUD_LOW};
      line_control_one <= RST_LINE_CTRL;
      tx_enable_bit <= 1'b0;
      rx_enable_bit <= 1'b0;
      gen_armed <= 1'b0;
    end else if (wr_fire && w_strb[0]) begin
      if (hit(aw_addr, ADDR_BAUD_HIGH)) begin
        baud_divisor_high <= wbyte & BAUD_HIGH_MASK;
        div_high_buf <= wbyte[BH_DIV_MSB:0];
      end
      if (hit(aw_addr, ADDR_BAUD_LOW)) begin
        baud_divisor_low <= wbyte;
        baud_divisor <= {div_high_buf, wbyte};
      end
      if (hit(aw_addr, ADDR_LINE_CTRL)) begin
        line_control_one <= wbyte;
      end
      if (hit(aw_addr, ADDR_AUX_CTRL)) begin
        tx_enable_bit <= wbyte[AX_TE];
        rx_enable_bit <= wbyte[AX_RE];
        if (wbyte[AX_TE] || wbyte[AX_RE]) begin
          gen_armed <= 1'b1;
        end
      end
    end
  end
  // ************************************************************
  // Event flags; set wins over the write-one clear
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      break_detect_flag <= 1'b0;
      rx_edge_flag <= 1'b0;
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_line;
      if (break_event_in && rx_enable_bit) begin
        break_detect_flag <= 1'b1;
      end else if (wr_fire && w_strb[0] && hit(aw_addr, ADDR_FLAGS) && wbyte[FL_BRK]) begin
        break_detect_flag <= 1'b0;
      end
      if (clk_run && rx_prev && !rx_line) begin
        rx_edge_flag <= 1'b1;
      end else if (wr_fire && w_strb[0] && hit(aw_addr, ADDR_FLAGS) && wbyte[FL_EDGE]) begin
        rx_edge_flag <= 1'b0;
      end
    end
  end
  // Interrupt request from gated flags
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (baud_divisor_high[BH_BRK_IE] && break_detect_flag)
              || (baud_divisor_high[BH_EDGE_IE] && rx_edge_flag);
    end
  end
  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= RESP_OKAY;
        case (s_axi_araddr_in)
          ADDR_BAUD_HIGH: s_axi_rdata_out <= {24'h000000, baud_divisor_high};
          ADDR_BAUD_LOW: s_axi_rdata_out <= {24'h000000, baud_divisor_low};
          ADDR_LINE_CTRL: s_axi_rdata_out <= {24'h000000, line_control_one};
          ADDR_AUX_CTRL: s_axi_rdata_out <= {28'h0000000, tx_enable_bit, rx_enable_bit, 2'b00};
          ADDR_FLAGS: s_axi_rdata_out <= {30'h00000000, break_detect_flag, rx_edge_flag};
          ADDR_TX_DATA: s_axi_rdata_out <= {30'h00000000, buf_cnt};
          ADDR_RX_DATA: s_axi_rdata_out <= {23'h000000, rx_char_out};
          ADDR_STATUS: s_axi_rdata_out <= {28'h0000000, gen_armed, clk_run, tx_busy, rx_busy};
          default: begin
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
  // ************************************************************
  // Transmit buffer, two entries
  // ************************************************************
  assign buf_in_valid = wr_fire && hit(aw_addr, ADDR_TX_DATA) && (w_strb[0] || w_strb[1]);
  assign buf_in_ready = (buf_cnt != 2'd2);
  assign buf_out_valid = (buf_cnt != 2'd0);
  assign buf_out_ready = clk_run && tx_enable_bit && !tx_busy;
  // A write to a full buffer is dropped; the depth reads back at ADDR_TX_DATA
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'd0;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_mem[buf_wp] <= '{data: w_data[8:0]};
        buf_wp <= !buf_wp;
      end
      if (buf_out_valid && buf_out_ready) begin
        buf_rp <= !buf_rp;
      end
      buf_cnt <= buf_cnt + 2'((buf_in_valid && buf_in_ready) ? 1 : 0)
                         - 2'((buf_out_valid && buf_out_ready) ? 1 : 0);
    end
  end
  // ************************************************************
  // Baud generator: one tick per sixteenth of a bit
  // ************************************************************
  assign clk_run = gen_armed && (baud_divisor != DIV_ZERO)
                && !(cpu_wait_in && line_control_one.freeze_in_wait);
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !clk_run) begin
      div_cnt <= 13'h0001;
      os_tick <= 1'b0;
      os_cnt <= TICK_ZERO;
      bit_tick_out <= 1'b0;
    end else begin
      os_tick <= (div_cnt == baud_divisor);
      div_cnt <= (div_cnt == baud_divisor) ? 13'h0001 : div_cnt + 13'h0001;
      if (div_cnt == baud_divisor) begin
        os_cnt <= os_cnt + 4'h1;
      end
      bit_tick_out <= (div_cnt == baud_divisor) && (os_cnt == OVERSAMPLE_LAST);
    end
  end
  // ************************************************************
  // Transmitter with parity and nine-bit option
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_busy <= 1'b0;
      tx_shift <= '1;
      tx_left <= TICK_ZERO;
      tx_os <= TICK_ZERO;
    end else if (buf_out_valid && buf_out_ready) begin
      tx_busy <= 1'b1;
      tx_os <= TICK_ZERO;
      tx_left <= line_control_one.nine_bit ? BITS_NINE + 4'h2 : BITS_EIGHT + 4'h2;
      if (line_control_one.nine_bit) begin
        tx_shift <= {1'b1, line_control_one.parity_enable
          ? char_parity(buf_mem[buf_rp].data, 1'b1) ^ line_control_one.parity_odd_select
          : buf_mem[buf_rp].data[8], buf_mem[buf_rp].data[7:0], 1'b0};
      end else begin
        tx_shift <= {2'b11, line_control_one.parity_enable
          ? char_parity(buf_mem[buf_rp].data, 1'b0) ^ line_control_one.parity_odd_select
          : buf_mem[buf_rp].data[7], buf_mem[buf_rp].data[6:0], 1'b0};
      end
    end else if (tx_busy && os_tick) begin
      tx_os <= tx_os + 4'h1;
      if (tx_os == OVERSAMPLE_LAST) begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_left <= tx_left - 4'h1;
        tx_busy <= (tx_left != 4'h1);
      end
    end
  end
  // Pin drive and routing
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_pin_out <= 1'b1;
      tx_pin_oe_out <= 1'b0;
      rx_pin_serial_out <= 1'b0;
    end else begin
      tx_pin_out <= tx_busy ? tx_shift[0] : 1'b1;
      tx_pin_oe_out <= tx_enable_bit || tx_busy;
      rx_pin_serial_out <= rx_enable_bit && !line_control_one.loop_sel;
    end
  end
  // Receiver input selection
  always_comb begin
    if (!line_control_one.loop_sel) begin
      rx_line = rx_pin_in;
    end else if (line_control_one.receiver_source) begin
      rx_line = tx_pin_oe_out ? tx_pin_out : tx_pin_in;
    end else begin
      rx_line = tx_pin_out;
    end
  end
  // ************************************************************
  // Receiver, idle detection and parity check
  // ************************************************************
  assign stop_ok = rx_line;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_busy <= 1'b0;
      rx_os <= TICK_ZERO;
      rx_bits <= TICK_ZERO;
      rx_shift <= '0;
      rx_char_out <= '0;
      rx_char_valid_out <= 1'b0;
      parity_error_out <= 1'b0;
    end else begin
      rx_char_valid_out <= 1'b0;
      if (!rx_busy && rx_enable_bit && clk_run && rx_prev && !rx_line) begin
        rx_busy <= 1'b1;
        rx_os <= TICK_ZERO;
        rx_bits <= TICK_ZERO;
      end else if (rx_busy && os_tick) begin
        rx_os <= rx_os + 4'h1;
        if (rx_os == 4'h7 && rx_bits != TICK_ZERO) begin
          if (rx_bits <= (line_control_one.nine_bit ? BITS_NINE : BITS_EIGHT)) begin
            rx_shift <= line_control_one.nine_bit ? {rx_line, rx_shift[8:1]}
                                                 : {1'b0, rx_line, rx_shift[7:1]};
          end else begin
            rx_busy <= 1'b0;
            rx_char_out <= rx_shift;
            rx_char_valid_out <= stop_ok;
            parity_error_out <= line_control_one.parity_enable
              && ((^rx_shift) != line_control_one.parity_odd_select);
          end
        end
        if (rx_os == OVERSAMPLE_LAST) begin
          rx_bits <= rx_bits + 4'h1;
        end
      end
    end
  end
  // Idle count of consecutive high bit times
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      idle_cnt <= TICK_ZERO;
      idle_line_out <= 1'b0;
    end else begin
      if (!rx_line || (rx_busy && line_control_one.idle_after_stop)) begin
        idle_cnt <= TICK_ZERO;
      end else if (bit_tick_out && idle_cnt != OVERSAMPLE_LAST) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
      idle_line_out <= idle_cnt >= (line_control_one.nine_bit ? IDLE_BITS_LONG
                                                              : IDLE_BITS_SHORT);
    end
  end
endmodule
`default_nettype wire

// *** bench/serial_cfg_core_monitor.sv ***
// Checker on the ports of the serial configuration core
`default_nettype none
module serial_cfg_core_monitor
  import serial_cfg_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic cpu_wait_in,
  input wire logic rx_pin_serial_out,
  input wire logic bit_tick_out,
  input wire logic irq_out
);
  logic [7:0] wa, wd, hi, lc;
  logic [12:0] div;
  logic armed, re, dirty;
  logic [17:0] gap;
  // Write address and data held from their own handshakes
  always_ff @(posedge sys_clk_in) begin
    if (s_axi_awvalid_in && s_axi_awready_out) wa <= s_axi_awaddr_in;
    if (s_axi_wvalid_in && s_axi_wready_out) wd <= s_axi_wdata_in[7:0];
  end
  // Register shadow, updated when an accepted write is answered
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      hi <= RST_BAUD_HIGH;
      lc <= RST_LINE_CTRL;
      div <= {5'h00, RST_BAUD_LOW};
      armed <= 1'b0;
      re <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in && s_axi_bresp_out == RESP_OKAY) begin
      if (wa == ADDR_BAUD_HIGH) hi <= wd;
      if (wa == ADDR_BAUD_LOW) div <= {hi[BH_DIV_MSB:0], wd};
      if (wa == ADDR_LINE_CTRL) lc <= wd;
      if (wa == ADDR_AUX_CTRL) re <= wd[AX_RE];
      if (wa == ADDR_AUX_CTRL) armed <= armed | wd[AX_RE] | wd[AX_TE];
    end
  end
  // Cycles between ticks; a gap that spans a write or a wait is not judged
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      gap <= 18'h00000;
      dirty <= 1'b1;
    end else begin
      gap <= bit_tick_out ? 18'h00001 : gap + 18'h00001;
      if (bit_tick_out || s_axi_bvalid_out || cpu_wait_in) dirty <= s_axi_bvalid_out | cpu_wait_in;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence ar_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  sequence read_answer;
    s_axi_rvalid_out;
  endsequence
  chk_read_answer: assert property (ar_taken |=> read_answer)
    else $error("read not answered next cycle");
  chk_bresp_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  chk_unarmed_quiet: assert property (!armed [*2] |-> !bit_tick_out)
    else $error("tick before arming");
  chk_zero_quiet: assert property (div == DIV_ZERO [*3] |-> !bit_tick_out)
    else $error("tick with zero divisor");
  chk_tick_period: assert property (bit_tick_out && !dirty |-> gap == {div, 4'h0})
    else $error("bit period wrong");
  chk_freeze_quiet: assert property ((lc[LC_FREEZE] && cpu_wait_in) [*3] |-> !bit_tick_out)
    else $error("tick while frozen");
  chk_irq_gated: assert property (!(hi[BH_BRK_IE] || hi[BH_EDGE_IE]) [*2] |-> !irq_out)
    else $error("interrupt with enables clear");
  chk_rx_pin_used: assert property ((re && !lc[LC_LOOP]) [*3] |-> $past(rx_pin_serial_out))
    else $error("receive pin not used");
  chk_rx_pin_freed: assert property ((!re || lc[LC_LOOP]) [*3] |-> !$past(rx_pin_serial_out))
    else $error("receive pin not freed");
endmodule
bind serial_cfg_core serial_cfg_core_monitor mon (.*);
`default_nettype wire

// *** bench/serial_far_end.sv ***
// Remote serial transceiver on the far end of the port pins
`default_nettype none
module serial_far_end (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int period = 16;
  // Line rests at the mark level between frames
  initial line_out = 1'b1;
  // Start, data least significant first, stop, one bit time each
  task automatic send(input logic [8:0] data, input int nbits);
    line_out <= 1'b0;
    repeat (period) @(posedge clk_in);
    for (int i = 0; i < nbits; i++) begin
      line_out <= data[i];
      repeat (period) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (period) @(posedge clk_in);
  endtask
  // Sample a frame at mid bit after the start edge
  task automatic capture(input int nbits, output logic [8:0] data, output logic stop);
    data = 9'h000;
    @(negedge line_in);
    repeat (period / 2) @(posedge clk_in);
    for (int i = 0; i < nbits; i++) begin
      repeat (period) @(posedge clk_in);
      data[i] = line_in;
    end
    repeat (period) @(posedge clk_in);
    stop = line_in;
  endtask
endmodule
`default_nettype wire

// *** bench/uart_baud_and_frame_config_tb_top.sv ***
// Testbench for the serial configuration core
`default_nettype none
module uart_baud_and_frame_config_tb_top
  import serial_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic s_axi_rready_in, cpu_wait_in, break_event_in, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, tx_pin_out, tx_pin_oe_out;
  logic rx_pin_serial_out, bit_tick_out, irq_out, rx_char_valid_out, parity_error_out;
  logic idle_line_out, rx_pin_in, tx_pin_in, stp;
  logic [ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
  logic [8:0] rx_char_out, cap;
  logic [7:0] lcs [4] = '{8'h02, 8'h03, 8'h10, 8'h13};
  logic [8:0] dats [4] = '{9'h05B, 9'h05B, 9'h1A5, 9'h0A5};
  logic [8:0] exps [4] = '{9'h0DB, 9'h05B, 9'h1A5, 9'h1A5};
  int failures = 0;
  int tests_run = 0;
  int n;
  // Clock and pin wiring; the transmit pin has a pull-up
  always #5 sys_clk_in = ~sys_clk_in;
  assign tx_pin_in = tx_pin_oe_out ? tx_pin_out : 1'b1;
  serial_cfg_core dut (.*);
  serial_far_end far (.clk_in(sys_clk_in), .line_in(tx_pin_in), .line_out(rx_pin_in));
  // ************************************************************
  // Bus, compare and measurement tasks
  // ************************************************************
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    rdat = s_axi_rdata_out;
    rs = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    cmp("register", exp, rdat);
  endtask
  task automatic count_ticks(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge sys_clk_in);
      if (bit_tick_out === 1'b1) n++;
    end
  endtask
  task automatic tick_gap();
    do @(posedge sys_clk_in); while (bit_tick_out !== 1'b1);
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (bit_tick_out !== 1'b1);
  endtask
  task automatic get_rx(input logic [8:0] exp);
    do @(posedge sys_clk_in); while (rx_char_valid_out !== 1'b1);
    cmp("rx char", {23'h0, exp}, {23'h0, rx_char_out});
  endtask
  // Watchdog over the whole run
  initial begin
    #700000;
    failures++;
    conclude();
  end
  // Main sequence
  initial begin
    {rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 4'h0;
    {s_axi_arvalid_in, s_axi_rready_in, cpu_wait_in, break_event_in} = 4'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = 52'hF;
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    chk_reg(ADDR_BAUD_HIGH, 32'h00);
    chk_reg(ADDR_BAUD_LOW, 32'h04);
    chk_reg(ADDR_LINE_CTRL, 32'h00);
    count_ticks(200);
    cmp("ticks unarmed", 0, n);
    wr(ADDR_BAUD_HIGH, 32'hFF);
    chk_reg(ADDR_BAUD_HIGH, 32'hDF);
    chk_reg(ADDR_BAUD_LOW, 32'h04);
    rd(8'h20);
    cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(ADDR_BAUD_HIGH, 32'h00);
    wr(ADDR_BAUD_LOW, 32'h01);
    wr(ADDR_AUX_CTRL, 32'h0C);
    tick_gap();
    cmp("bit period", 16, n);
    wr(ADDR_BAUD_HIGH, 32'h01);
    tick_gap();
    cmp("period held", 16, n);
    wr(ADDR_BAUD_LOW, 32'h00);
    tick_gap();
    cmp("long period", 4096, n);
    wr(ADDR_BAUD_HIGH, 32'h00);
    wr(ADDR_BAUD_LOW, 32'h00);
    count_ticks(300);
    cmp("ticks zero", 0, n);
    wr(ADDR_BAUD_LOW, 32'h01);
    wr(ADDR_LINE_CTRL, 32'h40);
    cpu_wait_in <= 1'b1;
    count_ticks(100);
    cmp("ticks frozen", 0, n);
    wr(ADDR_LINE_CTRL, 32'h00);
    count_ticks(100);
    cmp("ticks in wait", 1, n > 5);
    cpu_wait_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_LINE_CTRL, {24'h0, lcs[i]});
      fork
        far.capture(lcs[i][LC_NINE] ? 9 : 8, cap, stp);
        wr(ADDR_TX_DATA, {23'h0, dats[i]});
      join
      cmp("tx frame", {23'h0, exps[i]}, {23'h0, cap});
      cmp("stop bit", 1, stp);
    end
    wr(ADDR_LINE_CTRL, 32'h00);
    cmp("rx pin used", 1, rx_pin_serial_out);
    fork
      far.send(9'h03C, 8);
      get_rx(9'h03C);
    join
    wr(ADDR_LINE_CTRL, 32'h02);
    fork
      far.send(9'h0BC, 8);
      get_rx(9'h0BC);
    join
    @(posedge sys_clk_in);
    cmp("parity error", 1, parity_error_out);
    fork
      far.send(9'h03C, 8);
      get_rx(9'h03C);
    join
    @(posedge sys_clk_in);
    cmp("parity good", 0, parity_error_out);
    wr(ADDR_LINE_CTRL, 32'h80);
    @(posedge sys_clk_in);
    cmp("rx pin freed", 0, rx_pin_serial_out);
    fork
      wr(ADDR_TX_DATA, 32'h66);
      get_rx(9'h066);
    join
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_LINE_CTRL, 32'h1 << i);
      chk_reg(ADDR_LINE_CTRL, 32'h1 << i);
    end
    @(posedge sys_clk_in);
    break_event_in <= 1'b1;
    @(posedge sys_clk_in);
    break_event_in <= 1'b0;
    chk_reg(ADDR_FLAGS, 32'h03);
    cmp("irq masked", 0, irq_out);
    wr(ADDR_BAUD_HIGH, 32'h40);
    repeat (3) @(posedge sys_clk_in);
    cmp("irq edge", 1, irq_out);
    wr(ADDR_FLAGS, 32'h01);
    repeat (3) @(posedge sys_clk_in);
    cmp("irq edge clear", 0, irq_out);
    wr(ADDR_BAUD_HIGH, 32'h80);
    repeat (3) @(posedge sys_clk_in);
    cmp("irq break", 1, irq_out);
    conclude();
  end
endmodule
`default_nettype wire
